//--- rtl/tms_sequencer.sv
`timescale 1ns/1ns
`include "tms_consts.svh"
// What this block does
// RULE1: Six modes; each access command's option selects the governing mode.
// RULE2: Option chars: 0,1 single trigger/auto; 8,9,A,B FIFO trigger/auto/continue/repeat.
// RULE3: Single trigger accesses once at command, responds once, then idles.
// RULE4: Single trigger with no tag answers tag-absent, no retry.
// RULE5: Single auto waits for a tag, processes once, responds, idles.
// RULE6: Stop while single auto waits ends the pending command.
// RULE7: FIFO trigger and auto inhibit the tag after access.
// RULE8: FIFO trigger command switches the antenna to continuous oscillation.
// RULE9: FIFO trigger accesses once at once; no tag gives tag-absent.
// RULE10: After FIFO trigger or auto, antenna keeps oscillating.
// RULE11: FIFO auto waits for tag, processes once, responds, turns oscillation on.
// RULE12: Stop ending a waiting FIFO auto leaves oscillation running.
// RULE13: FIFO continue waits for next tag only after host acknowledge.
// RULE14: FIFO continue cycles detect, process, respond until stop.
// RULE15: FIFO repeat waits for next tag right after each response.
// RULE16: FIFO repeat keeps processing tags until stop arrives.
// RULE17: FIFO continue and repeat inhibit each processed tag.
// RULE18: Stop terminates FIFO continue and repeat operation.
// RULE19: Code 13 is stop and aborts the running command; a stop during access or reply ends it only after the reply completes.
// RULE20: Code 11 is the host acknowledge of a response.
// RULE21: Negative acknowledge in FIFO continue resends last response, no new access.
module tms_sequencer (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cmdValid,
   input wire tms_pkg::tms_byte_t cmdCode,
   input wire tms_pkg::tms_byte_t cmdOption,
   input wire logic tagPresentPin,
   input wire logic accessDone,
   input wire logic accessOk,
   input wire logic accByteValid,
   input wire tms_pkg::tms_byte_t accByte,
   input wire logic respReady,
   output logic accessStart,
   output logic tagInhibit,
   output logic antennaOn,
   output logic busy,
   output logic respValid,
   output logic respLast,
   output tms_pkg::tms_byte_t respByte
);
   import tms_pkg::*;

   function automatic logic optValid(input tms_byte_t c);
      case (c)
         `TMS_OPT_SINGLE_TRIG, `TMS_OPT_SINGLE_AUTO, `TMS_OPT_FIFO_TRIG,
         `TMS_OPT_FIFO_AUTO, `TMS_OPT_FIFO_CONT, `TMS_OPT_FIFO_REP: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   function automatic tms_mode_e optMode(input tms_byte_t c);
      case (c)
         `TMS_OPT_SINGLE_AUTO: return MODE_SINGLE_AUTO;
         `TMS_OPT_FIFO_TRIG: return MODE_FIFO_TRIG;
         `TMS_OPT_FIFO_AUTO: return MODE_FIFO_AUTO;
         `TMS_OPT_FIFO_CONT: return MODE_FIFO_CONT;
         `TMS_OPT_FIFO_REP: return MODE_FIFO_REP;
         default: return MODE_SINGLE_TRIG;
      endcase
   endfunction

   function automatic logic isFifo(input tms_mode_e m);
      return m != MODE_SINGLE_TRIG && m != MODE_SINGLE_AUTO;
   endfunction

   function automatic logic waitsForTag(input tms_mode_e m);
      return m != MODE_SINGLE_TRIG && m != MODE_FIFO_TRIG;
   endfunction

   function automatic logic forcesOsc(input tms_mode_e m);
      return m == MODE_FIFO_TRIG || m == MODE_FIFO_AUTO;
   endfunction

   tms_state_e state;
   tms_state_e next_state;
   tms_mode_e mode;
   tms_mode_e next_mode;
   logic oscMode;
   logic next_oscMode;
   logic stopPend;
   logic next_stopPend;
   tms_byte_t respCode;
   tms_byte_t next_respCode;
   tms_addr_t wrCount;
   tms_addr_t next_wrCount;
   tms_addr_t rdAddr;
   tms_addr_t next_rdAddr;
   logic next_accessStart;
   logic next_tagInhibit;
   logic next_antennaOn;
   logic next_busy;
   logic next_respValid;
   logic next_respLast;
   logic memWrEn;
   tms_addr_t memWrAddr;
   tms_byte_t memWrData;
   logic tagSeen;
   logic accessCmd;
   logic stopCmd;
   logic ackCmd;
   logic nackCmd;

   tms_sync2 u_tag_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .asyncIn(tagPresentPin),
      .syncOut(tagSeen)
   );

   // Response kept whole so a refused reply can be sent again unchanged
   tms_resp_mem u_resp_mem (
      .ref_clk(ref_clk),
      .rst(rst),
      .wrEn(memWrEn),
      .wrAddr(memWrAddr),
      .wrData(memWrData),
      .rdAddr(rdAddr),
      .rdData(respByte)
   );

   always_comb begin
      accessCmd = cmdValid && cmdCode >= `TMS_CMD_FIRST_ACCESS
                  && cmdCode <= `TMS_CMD_LAST_ACCESS;
      stopCmd = cmdValid && cmdCode == `TMS_CMD_STOP; // see RULE19
      ackCmd = cmdValid && cmdCode == `TMS_CMD_ACK; // see RULE20
      nackCmd = cmdValid && cmdCode == `TMS_CMD_NACK;
   end

   always_comb begin
      next_state = state;
      next_mode = mode;
      next_oscMode = oscMode;
      next_stopPend = stopPend;
      next_respCode = respCode;
      next_wrCount = wrCount;
      next_rdAddr = rdAddr;
      next_accessStart = 1'b0;
      next_tagInhibit = 1'b0;
      next_respValid = respValid;
      next_respLast = respLast;
      memWrEn = 1'b0;
      memWrAddr = wrCount;
      memWrData = accByte;
      if (cmdValid && cmdCode == `TMS_CMD_OSC_ON) begin
         next_oscMode = 1'b1;
      end else if (cmdValid && cmdCode == `TMS_CMD_OSC_OFF) begin
         next_oscMode = 1'b0;
      end
      // Stop during access or reply is held so the reply still completes
      if (stopCmd && state != ST_IDLE && state != ST_WAIT_TAG && state != ST_ACK_WAIT) begin
         next_stopPend = 1'b1; // see RULE18
      end
      case (state)
         ST_IDLE: begin
            if (accessCmd && optValid(cmdOption)) begin
               next_mode = optMode(cmdOption); // see RULE1, see RULE2
               next_wrCount = `TMS_FIRST_DATA_ADDR;
               next_stopPend = 1'b0;
               if (forcesOsc(optMode(cmdOption))) begin
                  next_oscMode = 1'b1; // see RULE8, see RULE11
               end
               if (waitsForTag(optMode(cmdOption))) begin
                  next_state = ST_WAIT_TAG; // see RULE5, see RULE11, see RULE14
               end else if (tagSeen) begin
                  next_state = ST_ACCESS; // see RULE3, see RULE9
                  next_accessStart = 1'b1;
               end else begin
                  next_respCode = `TMS_CODE_TAG_ABSENT; // see RULE4, see RULE9
                  next_state = ST_FINISH;
               end
            end
         end
         ST_WAIT_TAG: begin
            if (stopCmd) begin
               // Oscillation flag untouched, so a FIFO auto stop keeps the field up
               next_state = ST_IDLE; // see RULE6, see RULE12, see RULE18
            end else if (tagSeen) begin
               next_state = ST_ACCESS;
               next_accessStart = 1'b1;
               next_wrCount = `TMS_FIRST_DATA_ADDR;
            end
         end
         ST_ACCESS: begin
            if (accByteValid && wrCount != `TMS_ADDR_MAX) begin
               memWrEn = 1'b1;
               next_wrCount = wrCount + 4'h1;
            end
            if (accessDone) begin
               next_respCode = accessOk ? `TMS_CODE_NORMAL : `TMS_CODE_TAG_ABSENT;
               next_tagInhibit = accessOk && isFifo(mode); // see RULE7, see RULE17
               next_state = ST_FINISH;
            end
         end
         ST_FINISH: begin
            memWrEn = 1'b1;
            memWrAddr = `TMS_RST_ADDR;
            memWrData = respCode;
            next_rdAddr = `TMS_RST_ADDR;
            next_state = ST_LOAD;
         end
         ST_LOAD: begin
            next_respValid = 1'b1;
            next_respLast = rdAddr == wrCount - 4'h1;
            next_state = ST_SHOW;
         end
         ST_SHOW: begin
            if (respReady) begin
               next_respValid = 1'b0;
               next_respLast = 1'b0;
               if (!respLast) begin
                  next_rdAddr = rdAddr + 4'h1;
                  next_state = ST_LOAD;
               end else if (stopPend || stopCmd) begin
                  next_stopPend = 1'b0;
                  next_state = ST_IDLE; // see RULE18
               end else if (mode == MODE_FIFO_REP) begin
                  next_state = ST_WAIT_TAG; // see RULE15, see RULE16
               end else if (mode == MODE_FIFO_CONT) begin
                  next_state = ST_ACK_WAIT; // see RULE13
               end else begin
                  next_state = ST_IDLE; // see RULE3, see RULE5
               end
            end
         end
         ST_ACK_WAIT: begin
            if (stopCmd) begin
               next_state = ST_IDLE; // see RULE14
            end else if (ackCmd) begin
               next_state = ST_WAIT_TAG; // see RULE13
            end else if (nackCmd) begin
               next_rdAddr = `TMS_RST_ADDR; // see RULE21
               next_state = ST_LOAD;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // Single modes with oscillation mode off power the field only while a command is live
      next_antennaOn = next_oscMode || next_state != ST_IDLE; // see RULE10
      next_busy = next_state != ST_IDLE;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         mode <= MODE_SINGLE_TRIG;
         oscMode <= 1'b0;
         stopPend <= 1'b0;
         respCode <= `TMS_CODE_NORMAL;
         wrCount <= `TMS_FIRST_DATA_ADDR;
         rdAddr <= `TMS_RST_ADDR;
         accessStart <= 1'b0;
         tagInhibit <= 1'b0;
         antennaOn <= 1'b0;
         busy <= 1'b0;
         respValid <= 1'b0;
         respLast <= 1'b0;
      end else begin
         state <= next_state;
         mode <= next_mode;
         oscMode <= next_oscMode;
         stopPend <= next_stopPend;
         respCode <= next_respCode;
         wrCount <= next_wrCount;
         rdAddr <= next_rdAddr;
         accessStart <= next_accessStart;
         tagInhibit <= next_tagInhibit;
         antennaOn <= next_antennaOn;
         busy <= next_busy;
         respValid <= next_respValid;
         respLast <= next_respLast;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence seqReplyEnd;
      state == ST_SHOW && respReady && respLast;
   endsequence

   sequence seqOscUp;
      oscMode ##1 antennaOn;
   endsequence

   AST_MODE_LATCH: assert property ( // see RULE1
      state == ST_IDLE && accessCmd && cmdOption == `TMS_OPT_FIFO_REP
      |=> mode == MODE_FIFO_REP && state == ST_WAIT_TAG)
      else $error("Option B did not select repeat mode");

   AST_TRIG_ABSENT: assert property ( // see RULE4
      state == ST_IDLE && accessCmd && cmdOption == `TMS_OPT_SINGLE_TRIG && !tagSeen
      |=> state == ST_FINISH && respCode == `TMS_CODE_TAG_ABSENT ##2 respValid)
      else $error("Missing tag did not give tag-absent reply");

   AST_SINGLE_ONCE: assert property ( // see RULE3
      seqReplyEnd and (mode == MODE_SINGLE_TRIG) ##0 !stopPend |=> state == ST_IDLE)
      else $error("Single trigger did not return to idle");

   AST_STOP_WAIT: assert property ( // see RULE6
      state == ST_WAIT_TAG && stopCmd |=> state == ST_IDLE && !accessStart)
      else $error("Stop did not end waiting command");

   AST_INHIBIT: assert property ( // see RULE7
      state == ST_ACCESS && accessDone && accessOk && isFifo(mode) |=> tagInhibit ##1 !tagInhibit)
      else $error("FIFO access did not inhibit tag");

   AST_OSC_FIFO: assert property ( // see RULE8
      state == ST_IDLE && accessCmd && cmdOption == `TMS_OPT_FIFO_TRIG |=> seqOscUp)
      else $error("FIFO trigger did not raise oscillation");

   AST_OSC_KEEP: assert property ( // see RULE12
      $fell(oscMode) |-> $past(cmdValid && cmdCode == `TMS_CMD_OSC_OFF))
      else $error("Oscillation dropped without off command");

   AST_ACK_ADV: assert property ( // see RULE13
      state == ST_ACK_WAIT && ackCmd && !stopCmd |=> state == ST_WAIT_TAG)
      else $error("Acknowledge did not rearm tag wait");

   AST_REPEAT: assert property ( // see RULE15
      seqReplyEnd ##0 (mode == MODE_FIFO_REP && !stopPend && !stopCmd)
      |=> state == ST_WAIT_TAG)
      else $error("Repeat mode did not rearm after reply");

   AST_NACK: assert property ( // see RULE21
      state == ST_ACK_WAIT && nackCmd && !stopCmd && !ackCmd
      |=> rdAddr == `TMS_RST_ADDR ##1 respValid && !accessStart)
      else $error("Negative acknowledge did not resend reply");
endmodule

//--- rtl/tms_consts.svh
`ifndef TMS_CONSTS_SVH
`define TMS_CONSTS_SVH

// Host command codes, two decimal digits carried as one byte
`define TMS_CMD_FIRST_ACCESS 8'h01
`define TMS_CMD_LAST_ACCESS 8'h08
`define TMS_CMD_ACK 8'h11
`define TMS_CMD_NACK 8'h12
`define TMS_CMD_STOP 8'h13
`define TMS_CMD_OSC_ON 8'h14
`define TMS_CMD_OSC_OFF 8'h15

// Transmission option characters
`define TMS_OPT_SINGLE_TRIG 8'h30
`define TMS_OPT_SINGLE_AUTO 8'h31
`define TMS_OPT_FIFO_TRIG 8'h38
`define TMS_OPT_FIFO_AUTO 8'h39
`define TMS_OPT_FIFO_CONT 8'h41
`define TMS_OPT_FIFO_REP 8'h42

// Completion codes placed in the first response byte
`define TMS_CODE_NORMAL 8'h00
`define TMS_CODE_TAG_ABSENT 8'h72

// Response store geometry
`define TMS_MEM_DEPTH 16
`define TMS_ADDR_MAX 4'hF

// Reset values
`define TMS_RST_BYTE 8'h00
`define TMS_RST_ADDR 4'h0
`define TMS_FIRST_DATA_ADDR 4'h1

`endif

//--- rtl/tms_pkg.sv
package tms_pkg;

   typedef logic [7:0] tms_byte_t;
   typedef logic [3:0] tms_addr_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_WAIT_TAG = 3'h1,
      ST_ACCESS = 3'h3,
      ST_FINISH = 3'h2,
      ST_LOAD = 3'h6,
      ST_SHOW = 3'h7,
      ST_ACK_WAIT = 3'h5
   } tms_state_e;

   typedef enum logic [2:0] {
      MODE_SINGLE_TRIG = 3'h0,
      MODE_SINGLE_AUTO = 3'h1,
      MODE_FIFO_TRIG = 3'h2,
      MODE_FIFO_AUTO = 3'h3,
      MODE_FIFO_CONT = 3'h4,
      MODE_FIFO_REP = 3'h5
   } tms_mode_e;

endpackage

//--- rtl/tms_sync2.sv
`timescale 1ns/1ns
module tms_sync2 (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic asyncIn,
   output logic syncOut
);
   logic stage1;
   logic next_stage1;
   logic next_syncOut;

   always_comb begin
      next_stage1 = asyncIn;
      next_syncOut = stage1;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stage1 <= 1'b0;
         syncOut <= 1'b0;
      end else begin
         stage1 <= next_stage1;
         syncOut <= next_syncOut;
      end
   end
endmodule

//--- rtl/tms_resp_mem.sv
`timescale 1ns/1ns
`include "tms_consts.svh"
module tms_resp_mem (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wrEn,
   input wire tms_pkg::tms_addr_t wrAddr,
   input wire tms_pkg::tms_byte_t wrData,
   input wire tms_pkg::tms_addr_t rdAddr,
   output tms_pkg::tms_byte_t rdData
);
   import tms_pkg::*;

   // Array has no reset; only read-back after a write is meaningful
   tms_byte_t store [`TMS_MEM_DEPTH];
   tms_byte_t next_rdData;

   always_comb begin
      next_rdData = store[rdAddr];
   end

   always_ff @(posedge ref_clk) begin
      if (wrEn) begin
         store[wrAddr] <= wrData;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdData <= `TMS_RST_BYTE;
      end else begin
         rdData <= next_rdData;
      end
   end
endmodule

//--- tb/tms_tag_engine.sv
`timescale 1ns/1ns
module tms_tag_engine #(
   parameter int NBYTES = 2
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic accessStart,
   input wire logic tagInhibit,
   input wire logic tagPut,
   input wire logic tagDrop,
   output logic tagPresentPin,
   output logic accessDone,
   output logic accessOk,
   output logic accByteValid,
   output tms_pkg::tms_byte_t accByte
);
   import tms_pkg::*;
   logic [3:0] cnt;
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tagPresentPin <= 1'b0;
         cnt <= 4'h0;
         accessDone <= 1'b0;
         accessOk <= 1'b0;
         accByteValid <= 1'b0;
         accByte <= 8'h00;
      end else begin
         accessDone <= 1'b0;
         accByteValid <= 1'b0;
         // Idle data lines toggle so a stale byte is never mistaken for a fresh one
         accByte <= ~accByte;
         // An inhibited tag goes silent until a fresh tag enters the field
         if (tagPut) begin
            tagPresentPin <= 1'b1;
         end else if (tagDrop || tagInhibit) begin
            tagPresentPin <= 1'b0;
         end
         if (accessStart) begin
            cnt <= 4'h1;
         end else if (cnt != 4'h0) begin
            cnt <= cnt + 4'h1;
         end
         if (cnt >= 4'h3 && cnt < 4'(3 + NBYTES)) begin
            accByteValid <= 1'b1;
            accByte <= 8'hA0 + {4'h0, cnt} - 8'h03;
         end
         if (cnt == 4'(3 + NBYTES)) begin
            accessDone <= 1'b1;
            accessOk <= tagPresentPin;
            cnt <= 4'h0;
         end
      end
   end
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ns
`include "tms_consts.svh"
module testbench;
   import tms_pkg::*;
   logic ref_clk = 1'b0;
   logic rst, cmdValid, respReady, tagPut, tagDrop;
   tms_byte_t cmdCode, cmdOption, accByte, respByte;
   logic tagPresentPin, accessDone, accessOk, accByteValid;
   logic accessStart, tagInhibit, antennaOn, busy, respValid, respLast;
   int num_errors = 0;
   int checked = 0;
   int starts = 0;
   int inhibits = 0;
   int s0;
   int i0;

   always #20 ref_clk = ~ref_clk;

   tms_sequencer tms_sequencer_inst (.ref_clk(ref_clk), .rst(rst), .cmdValid(cmdValid),
      .cmdCode(cmdCode), .cmdOption(cmdOption), .tagPresentPin(tagPresentPin),
      .accessDone(accessDone), .accessOk(accessOk), .accByteValid(accByteValid),
      .accByte(accByte), .respReady(respReady), .accessStart(accessStart),
      .tagInhibit(tagInhibit), .antennaOn(antennaOn), .busy(busy), .respValid(respValid),
      .respLast(respLast), .respByte(respByte));

   tms_tag_engine tms_tag_engine_inst (.ref_clk(ref_clk), .rst(rst),
      .accessStart(accessStart), .tagInhibit(tagInhibit), .tagPut(tagPut),
      .tagDrop(tagDrop), .tagPresentPin(tagPresentPin), .accessDone(accessDone),
      .accessOk(accessOk), .accByteValid(accByteValid), .accByte(accByte));

   // One-cycle pulses are counted at the falling edge, clear of update races
   always @(negedge ref_clk) begin
      if (accessStart === 1'b1) starts++;
      if (tagInhibit === 1'b1) inhibits++;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         num_errors++;
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task automatic send(input tms_byte_t code, input tms_byte_t opt);
      @(negedge ref_clk);
      cmdValid = 1'b1;
      cmdCode = code;
      cmdOption = opt;
      @(negedge ref_clk);
      cmdValid = 1'b0;
   endtask

   task automatic tag_pulse(input logic put);
      @(negedge ref_clk);
      tagPut = put;
      tagDrop = ~put;
      @(negedge ref_clk);
      tagPut = 1'b0;
      tagDrop = 1'b0;
      idle(3);
   endtask

   task automatic get_resp(input tms_byte_t code, input int n);
      int w;
      for (int i = 0; i <= n; i++) begin
         w = 0;
         while (respValid !== 1'b1 && w < 300) begin
            @(negedge ref_clk);
            w++;
         end
         check(8'(respValid), 8'h01);
         check(respByte, (i == 0) ? code : 8'hA0 + 8'(i - 1));
         check(8'(respLast), 8'(i == n));
         @(negedge ref_clk);
      end
   endtask

   task automatic wait_idle();
      int w;
      w = 0;
      while (busy !== 1'b0 && w < 100) begin
         @(negedge ref_clk);
         w++;
      end
      check(8'(busy), 8'h00);
   endtask

   task automatic scen_single_trig();
      tag_pulse(1'b1);
      s0 = starts;
      send(`TMS_CMD_FIRST_ACCESS, 8'h32);
      idle(2);
      check(8'(busy), 8'h00);
      check(8'(starts - s0), 8'h00);
      send(`TMS_CMD_FIRST_ACCESS, `TMS_OPT_SINGLE_TRIG);
      get_resp(`TMS_CODE_NORMAL, 2);
      wait_idle();
      check(8'(starts - s0), 8'h01);
      check(8'(antennaOn), 8'h00);
      tag_pulse(1'b0);
      // Receiver stalled: the reply byte must stand until it is taken
      respReady = 1'b0;
      send(`TMS_CMD_FIRST_ACCESS, `TMS_OPT_SINGLE_TRIG);
      idle(8);
      check(8'(respValid), 8'h01);
      check(respByte, `TMS_CODE_TAG_ABSENT);
      respReady = 1'b1;
      get_resp(`TMS_CODE_TAG_ABSENT, 0);
      wait_idle();
      check(8'(starts - s0), 8'h01);
   endtask

   task automatic scen_single_auto();
      s0 = starts;
      send(8'h02, `TMS_OPT_SINGLE_AUTO);
      idle(10);
      check(8'(busy), 8'h01);
      check(8'(starts - s0), 8'h00);
      tag_pulse(1'b1);
      get_resp(`TMS_CODE_NORMAL, 2);
      wait_idle();
      tag_pulse(1'b0);
      send(8'h02, `TMS_OPT_SINGLE_AUTO);
      idle(5);
      send(`TMS_CMD_STOP, 8'h00);
      idle(3);
      check(8'(busy), 8'h00);
      check(8'(respValid), 8'h00);
   endtask

   task automatic scen_fifo_trig_auto();
      tag_pulse(1'b1);
      i0 = inhibits;
      send(`TMS_CMD_FIRST_ACCESS, `TMS_OPT_FIFO_TRIG);
      idle(1);
      check(8'(antennaOn), 8'h01);
      get_resp(`TMS_CODE_NORMAL, 2);
      wait_idle();
      check(8'(inhibits - i0), 8'h01);
      check(8'(antennaOn), 8'h01);
      send(`TMS_CMD_FIRST_ACCESS, `TMS_OPT_FIFO_TRIG);
      get_resp(`TMS_CODE_TAG_ABSENT, 0);
      send(`TMS_CMD_FIRST_ACCESS, `TMS_OPT_FIFO_AUTO);
      idle(5);
      send(`TMS_CMD_STOP, 8'h00);
      idle(3);
      check(8'(busy), 8'h00);
      check(8'(antennaOn), 8'h01);
      send(`TMS_CMD_FIRST_ACCESS, `TMS_OPT_FIFO_AUTO);
      tag_pulse(1'b1);
      get_resp(`TMS_CODE_NORMAL, 2);
      wait_idle();
      check(8'(inhibits - i0), 8'h02);
      check(8'(antennaOn), 8'h01);
      send(`TMS_CMD_OSC_OFF, 8'h00);
      idle(2);
      check(8'(antennaOn), 8'h00);
   endtask

   task automatic scen_fifo_cont();
      send(`TMS_CMD_FIRST_ACCESS, `TMS_OPT_FIFO_CONT);
      tag_pulse(1'b1);
      get_resp(`TMS_CODE_NORMAL, 2);
      s0 = starts;
      tag_pulse(1'b1);
      idle(10);
      check(8'(starts - s0), 8'h00);
      send(`TMS_CMD_NACK, 8'h00);
      get_resp(`TMS_CODE_NORMAL, 2);
      check(8'(starts - s0), 8'h00);
      send(`TMS_CMD_ACK, 8'h00);
      get_resp(`TMS_CODE_NORMAL, 2);
      check(8'(starts - s0), 8'h01);
      send(`TMS_CMD_STOP, 8'h00);
      idle(3);
      check(8'(busy), 8'h00);
   endtask

   task automatic scen_fifo_rep();
      i0 = inhibits;
      send(`TMS_CMD_FIRST_ACCESS, `TMS_OPT_FIFO_REP);
      tag_pulse(1'b1);
      get_resp(`TMS_CODE_NORMAL, 2);
      tag_pulse(1'b1);
      get_resp(`TMS_CODE_NORMAL, 2);
      idle(5);
      check(8'(inhibits - i0), 8'h02);
      check(8'(busy), 8'h01);
      send(`TMS_CMD_STOP, 8'h00);
      idle(3);
      check(8'(busy), 8'h00);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      cmdValid = 1'b0;
      cmdCode = 8'h00;
      cmdOption = 8'h00;
      respReady = 1'b1;
      tagPut = 1'b0;
      tagDrop = 1'b0;
      repeat (10) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      idle(2);
      scen_single_trig();
      scen_single_auto();
      scen_fifo_trig_auto();
      scen_fifo_cont();
      scen_fifo_rep();
      give_verdict();
   end

   // The scenarios need well under two thousand cycles
   initial begin
      #(40 * 20000);
      num_errors++;
      give_verdict();
   end
endmodule
